// [include/vxi_window_defines.vh]
/*
 holds the address-decode constants of the backplane register window:
 configuration block placement, register offsets, window size, widths.
 assumes it is included by bare name in the decode files.
*/
`ifndef VXI_WINDOW_DEFINES_VH
`define VXI_WINDOW_DEFINES_VH

// configuration space placement
`define CFG_SPACE_START 24'h1FC000
`define CFG_BLOCK_BYTES 24'h000040
`define CFG_BLOCK_SHIFT 6
`define LOG_ADDR_DEFAULT 8'h28
// switch pins: edges after release before all three stages are filled
`define SW_SETTLE_COUNT 2'h3

// configuration register offsets within the 64-byte block
`define CFG_OFS_ID 6'h00
`define CFG_OFS_DEVTYPE 6'h02
`define CFG_OFS_STATUS 6'h04
`define CFG_OFS_BASE_OFFSET 6'h06

// device-type field: bits 15:12 give the window size code
`define DEVTYPE_SIZE_LSB 12
`define DEVTYPE_SIZE_CODE 4'h0
`define DEVTYPE_MODEL 12'h000
// window of 4096 bytes, base = register value * 256
`define WIN_BYTES 24'h001000
`define WIN_OFS_BITS 12
`define BASE_SHIFT 8
`define BASE_RESET 16'h0000
// window offsets that take 16-bit transfers
`define WIN_OFS_UPLOAD 12'h00C
`define WIN_OFS_WIDE 12'h00E

// identity value is arbitrary
`define MAKER_ID 12'hF00
`define ID_CLASS 4'hC

// reading size in bytes for memory upload
`define READING_BYTES 2

`endif

// [verilog/reading_byte_pair.v]
/*
 holds the byte sequencer for uploading acquisition readings: each
 16-bit reading leaves as two byte reads, high byte first.
 assumes the main decoder presents one pulse per accepted byte read.
*/
`timescale 1ns/10ps
`include "vxi_window_defines.vh"

module reading_byte_pair (
   // clock and reset
   input wire sys_clk,
   input wire nrst,
   // reading source
   input wire [15:0] reading_data,
   output wire reading_pop,
   // byte read side
   input wire byte_rd,
   output reg [7:0] byte_ff,
   output reg [15:0] bytes_sent_ff
);

   ////////////////////////////////////////////////////////////////////////
   reg half_ff;
   reg [7:0] nxt_byte;

   // pop after the low byte, so one reading spans two reads
   assign reading_pop = byte_rd & half_ff;

   always @* begin
      nxt_byte = half_ff ? reading_data[7:0] : reading_data[15:8];
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         half_ff <= 1'b0;
         byte_ff <= 8'h00;
         bytes_sent_ff <= 16'h0000;
      end else if (byte_rd) begin
         half_ff <= ~half_ff;
         byte_ff <= nxt_byte;
         bytes_sent_ff <= bytes_sent_ff + 16'h0001;
      end
   end

endmodule

// [verilog/vxi_register_window_decode.v]
/*
 holds the backplane address decoder: the 64-byte configuration block in
 24-bit address space, the window base register, and the 4096-byte window
 of byte-wide operating registers plus the reading upload port.
 assumes a decoded, synchronous strobe interface from the bus front end:
 one-cycle cfg and win strobes, already qualified by address modifier.
*/
// Operation
// - device-type register reports 4096-byte window need
// - store manager-written window base, keep it
// - config block at 1FC000 plus address times 64
// - base register at offset 06, 16-bit readable
// - window base equals register value times 256
// - operating registers decoded relative to window base
// - operating accesses byte-wide unless designated wider
// - each uploaded reading is two bytes
// - logical address defaults to 40
`timescale 1ns/10ps
`include "vxi_window_defines.vh"

module vxi_register_window_decode (
   // clock and reset
   input wire sys_clk,
   input wire nrst,
   // logical address switches, sampled after reset
   input wire [7:0] module_logical_address,
   input wire log_addr_use_default,
   // configuration space access
   input wire cfg_strobe,
   input wire cfg_write,
   input wire [23:0] cfg_addr,
   input wire [15:0] cfg_wdata,
   output reg [15:0] cfg_rdata_ff,
   output reg cfg_ack_ff,
   // window space access
   input wire win_strobe,
   input wire win_write,
   input wire win_wide,
   input wire [23:0] win_addr,
   input wire [15:0] win_wdata,
   output reg [15:0] win_rdata_ff,
   output reg win_ack_ff,
   output reg win_err_ff,
   // operating register side
   output reg [11:0] op_offset_ff,
   output reg [7:0] op_wdata_ff,
   output reg op_write_ff,
   output reg op_read_ff,
   input wire [7:0] op_rdata,
   // reading upload
   input wire [15:0] reading_data,
   output wire reading_pop,
   output wire [15:0] upload_bytes,
   // state shown to the module
   output wire [23:0] window_base,
   output wire [23:0] cfg_base
);

   ////////////////////////////////////////////////////////////////////////
   // upload port and the 16-bit data port are the only wide registers
   localparam [11:0] OFS_UPLOAD = `WIN_OFS_UPLOAD;
   localparam [11:0] OFS_WIDE_DATA = `WIN_OFS_WIDE;

   // one-hot access states
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_OP = 3'b010;
   localparam [2:0] ST_UPL = 3'b100;

   reg [7:0] log_addr_ff;
   reg addr_taken_ff;
   // switch pins: three stages, with a settle count of three edges running alongside them from release
   reg [8:0] sw_s1_ff;
   reg [8:0] sw_s2_ff;
   reg [8:0] sw_s3_ff;
   reg [1:0] settle_ff;
   reg win_wide_ff;
   reg [15:0] base_reg_ff;
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg upl_rd;
   wire [7:0] upl_byte;
   wire in_cfg;
   wire in_win;
   wire [23:0] win_rel;
   wire wide_ok;

   ////////////////////////////////////////////////////////////////////////
   function [23:0] cfg_block_base;
      input [7:0] la;
      begin
         cfg_block_base = `CFG_SPACE_START +
            ({16'h0000, la} << `CFG_BLOCK_SHIFT);
      end
   endfunction

   function [23:0] win_base_of;
      input [15:0] ofs;
      begin
         win_base_of = {ofs, 8'h00};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // switch pins are asynchronous to sys_clk: three stages first
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sw_s1_ff <= 9'h000;
         sw_s2_ff <= 9'h000;
         sw_s3_ff <= 9'h000;
         settle_ff <= 2'h0;
      end else begin
         sw_s1_ff <= {log_addr_use_default, module_logical_address};
         sw_s2_ff <= sw_s1_ff;
         sw_s3_ff <= sw_s2_ff;
         if (settle_ff != `SW_SETTLE_COUNT)
            settle_ff <= settle_ff + 2'h1;
      end
   end

   // caught once, when the stages are filled and the last two agree; a switch still
   // moving at release only delays the catch
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         log_addr_ff <= `LOG_ADDR_DEFAULT;
         addr_taken_ff <= 1'b0;
      end else if (!addr_taken_ff && settle_ff == `SW_SETTLE_COUNT &&
                   sw_s2_ff == sw_s3_ff) begin
         addr_taken_ff <= 1'b1;
         if (!sw_s3_ff[8])
            log_addr_ff <= sw_s3_ff[7:0];
      end
   end

   assign cfg_base = cfg_block_base(log_addr_ff);
   assign window_base = win_base_of(base_reg_ff);
   assign in_cfg = (cfg_addr[23:6] == cfg_base[23:6]);
   assign win_rel = win_addr - window_base;
   // base is 256-aligned, so the window may straddle a 4k line
   assign in_win = (win_rel < `WIN_BYTES);
   assign wide_ok = (win_rel[11:0] == OFS_UPLOAD) |
                    (win_rel[11:0] == OFS_WIDE_DATA);

   ////////////////////////////////////////////////////////////////////////
   // configuration block
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         base_reg_ff <= `BASE_RESET;
         cfg_rdata_ff <= 16'h0000;
         cfg_ack_ff <= 1'b0;
      end else begin
         cfg_ack_ff <= cfg_strobe & in_cfg;
         if (cfg_strobe && in_cfg) begin
            if (cfg_write) begin
               if (cfg_addr[5:0] == `CFG_OFS_BASE_OFFSET)
                  base_reg_ff <= cfg_wdata;
            end else if (cfg_addr[5:0] == `CFG_OFS_ID) begin
               cfg_rdata_ff <= {`ID_CLASS, `MAKER_ID};
            end else if (cfg_addr[5:0] == `CFG_OFS_DEVTYPE) begin
               cfg_rdata_ff <= {`DEVTYPE_SIZE_CODE,
                                `DEVTYPE_MODEL};
            end else if (cfg_addr[5:0] == `CFG_OFS_STATUS) begin
               cfg_rdata_ff <= {15'h0000, addr_taken_ff};
            end else if (cfg_addr[5:0] == `CFG_OFS_BASE_OFFSET) begin
               cfg_rdata_ff <= base_reg_ff;
            end else begin
               cfg_rdata_ff <= 16'h0000;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // window access sequencer
   always @* begin
      nxt_state = ST_IDLE;
      upl_rd = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (win_strobe && in_win && !(win_wide && !wide_ok)) begin
               if (win_rel[11:0] == OFS_UPLOAD && !win_write) begin
                  nxt_state = ST_UPL;
                  upl_rd = 1'b1;
               end else begin
                  nxt_state = ST_OP;
               end
            end
         end
         ST_OP: nxt_state = ST_IDLE;
         ST_UPL: begin
            // second byte of a wide upload read
            upl_rd = win_wide_ff;
            nxt_state = ST_IDLE;
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= ST_IDLE;
         win_wide_ff <= 1'b0;
         op_offset_ff <= 12'h000;
         op_wdata_ff <= 8'h00;
         op_write_ff <= 1'b0;
         op_read_ff <= 1'b0;
         win_rdata_ff <= 16'h0000;
         win_ack_ff <= 1'b0;
         win_err_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         op_write_ff <= 1'b0;
         op_read_ff <= 1'b0;
         win_ack_ff <= 1'b0;
         // outside the window: no answer at all
         win_err_ff <= (state_ff == ST_IDLE) & win_strobe & in_win &
                       win_wide & ~wide_ok;
         if (state_ff == ST_IDLE && win_strobe && in_win) begin
            win_wide_ff <= win_wide;
            op_offset_ff <= win_rel[11:0];
            op_wdata_ff <= win_wdata[7:0];
            if (!(win_wide && !wide_ok)) begin
               op_write_ff <= win_write;
               op_read_ff <= ~win_write &
                             (win_rel[11:0] != OFS_UPLOAD);
            end
         end
         if (state_ff == ST_OP) begin
            win_ack_ff <= 1'b1;
            win_rdata_ff <= {8'h00, op_rdata};
         end
         if (state_ff == ST_UPL) begin
            win_ack_ff <= 1'b1;
            // byte_ff already holds the byte sequenced in the idle cycle, high or low
            win_rdata_ff <= win_wide_ff ? reading_data :
                            {8'h00, upl_byte};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   reading_byte_pair pair_u (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .reading_data(reading_data),
      .reading_pop(reading_pop),
      .byte_rd(upl_rd),
      .byte_ff(upl_byte),
      .bytes_sent_ff(upload_bytes)
   );

endmodule

// [testbench/vxi_window_checker_props.sv]
/*
 checker for the window decoder, bound to its top ports.
 assumes window requests at least two cycles apart.
*/
`timescale 1ns/10ps
module vxi_window_checker (
   // clock, reset and watched ports
   input wire sys_clk, nrst, cfg_strobe, cfg_write, win_strobe, win_write,
   input wire win_wide, cfg_ack_ff, win_ack_ff, win_err_ff,
   input wire op_write_ff, op_read_ff,
   input wire [23:0] cfg_addr, win_addr, window_base, cfg_base,
   input wire [15:0] cfg_wdata, cfg_rdata_ff,
   input wire [11:0] op_offset_ff
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire hit = cfg_addr[23:6] == cfg_base[23:6];
   wire [23:0] wofs = win_addr - window_base;
   wire in_win = wofs < 24'h001000;
   wire wide_ok = wofs == 24'h00C || wofs == 24'h00E;
   // upload reads go to the byte sequencer, not the operating side
   wire upl = wofs == 24'h00C && !win_write;
   property p_cfg_hit;
      cfg_strobe && hit |=> cfg_ack_ff;
   endproperty
   a_cfg_hit: assert property (p_cfg_hit) else $error("no cfg ack");
   property p_cfg_miss;
      cfg_strobe && !hit |=> !cfg_ack_ff;
   endproperty
   a_cfg_miss: assert property (p_cfg_miss) else $error("bad ack");
   property p_base;
      cfg_ack_ff && $past(cfg_write) && $past(cfg_addr[5:0]) == 6'h06
      |-> window_base == {$past(cfg_wdata), 8'h00};
   endproperty
   a_base: assert property (p_base) else $error("base wrong");
   property p_size;
      cfg_strobe && hit && !cfg_write && cfg_addr[5:0] == 6'h02
      |=> cfg_rdata_ff[15:12] == 4'h0;
   endproperty
   a_size: assert property (p_size) else $error("size code");
   property p_outside;
      win_strobe && !in_win |=> !win_err_ff ##1 !win_ack_ff;
   endproperty
   a_outside: assert property (p_outside) else $error("outside");
   property p_win_hit;
      win_strobe && in_win && !win_wide
      |=> ((op_read_ff ^ op_write_ff) != $past(upl)) ##1 win_ack_ff;
   endproperty
   a_win_hit: assert property (p_win_hit) else $error("no ack");
   property p_ofs;
      op_read_ff || op_write_ff
      |-> op_offset_ff == $past(win_addr[11:0]) - $past(window_base[11:0]);
   endproperty
   a_ofs: assert property (p_ofs) else $error("offset wrong");
   property p_wide;
      win_strobe && in_win && win_wide && !wide_ok
      |=> win_err_ff ##1 !win_ack_ff;
   endproperty
   a_wide: assert property (p_wide) else $error("wide taken");
endmodule
bind vxi_register_window_decode vxi_window_checker i_chk (.sys_clk, .nrst,
   .cfg_strobe, .cfg_write, .win_strobe, .win_write, .win_wide, .cfg_ack_ff,
   .win_ack_ff, .win_err_ff, .op_write_ff, .op_read_ff, .cfg_addr,
   .win_addr, .window_base, .cfg_base, .cfg_wdata, .cfg_rdata_ff,
   .op_offset_ff);

// [testbench/vme_master_model.sv]
/*
 resource manager bus master: one access task for both spaces.
 assumes one-cycle strobes and answers within three cycles.
*/
`timescale 1ns/10ps
module vme_master_model (
   // clock and answers
   input wire sys_clk, cfg_ack_ff, win_ack_ff, win_err_ff,
   input wire [15:0] cfg_rdata_ff, win_rdata_ff,
   // requests
   output logic cfg_strobe = 0, cfg_write = 0, win_strobe = 0,
   output logic win_write = 0, win_wide = 0,
   output logic [23:0] cfg_addr = 0, win_addr = 0,
   output logic [15:0] cfg_wdata = 0, win_wdata = 0
);
   task automatic acc(input logic w, wr, wd, input logic [23:0] a,
      input logic [15:0] d, output logic ack, err, output logic [15:0] q);
      @(posedge sys_clk);
      #1;
      if (w) begin
         {win_strobe, win_write, win_wide} = {1'b1, wr, wd};
         {win_addr, win_wdata} = {a, d};
      end else begin
         {cfg_strobe, cfg_write, cfg_addr, cfg_wdata} = {1'b1, wr, a, d};
      end
      {ack, err, q} = 0;
      repeat (3) begin
         @(posedge sys_clk);
         #1;
         {cfg_strobe, win_strobe} = 2'b00;
         // released lines flip so stale values never look valid
         {cfg_addr, win_addr} = ~{cfg_addr, win_addr};
         {cfg_wdata, win_wdata} = ~{cfg_wdata, win_wdata};
         err |= win_err_ff;
         if (cfg_ack_ff | win_ack_ff) q = w ? win_rdata_ff : cfg_rdata_ff;
         ack |= cfg_ack_ff | win_ack_ff;
      end
   endtask
endmodule

// [testbench/test_vxi_register_window_decode.sv]
/*
 self-checking bench of the window decoder with a bus master model.
 assumes the header is on the include path.
*/
`timescale 1ns/10ps
module test_vxi_register_window_decode;
   logic sys_clk = 0, nrst = 0, use_def = 1, ack, err;
   logic [7:0] la = 0;
   logic [15:0] rdg = 16'hA1B2, q, v, e;
   logic [23:0] cb, wb;
   int num_errors = 0, total_checks = 0, cycles = 0;
   // model count of upload bytes handed out
   int nb = 0;
   wire cs, cw, ws, ww, wd, ca, wa, we, ow, orr, pop;
   wire [23:0] caddr, waddr, wbase, cbase;
   wire [15:0] cwd, wwd, crd, wrd, ub;
   wire [11:0] oofs;
   wire [7:0] owd;
   // operating registers answer with a pattern of their offset
   wire [7:0] ord = oofs[7:0] ^ 8'h5A;
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (pop) rdg <= rdg + 16'h1357;
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles > 3000) begin
         num_errors++;
         close_out;
      end
   end
   vme_master_model i_master (.sys_clk, .cfg_ack_ff(ca), .win_ack_ff(wa),
      .win_err_ff(we), .cfg_rdata_ff(crd), .win_rdata_ff(wrd),
      .cfg_strobe(cs), .cfg_write(cw), .win_strobe(ws), .win_write(ww),
      .win_wide(wd), .cfg_addr(caddr), .win_addr(waddr),
      .cfg_wdata(cwd), .win_wdata(wwd));
   vxi_register_window_decode i_vxi_register_window_decode (.sys_clk,
      .nrst, .module_logical_address(la), .log_addr_use_default(use_def),
      .cfg_strobe(cs), .cfg_write(cw), .cfg_addr(caddr), .cfg_wdata(cwd),
      .cfg_rdata_ff(crd), .cfg_ack_ff(ca), .win_strobe(ws),
      .win_write(ww), .win_wide(wd), .win_addr(waddr), .win_wdata(wwd),
      .win_rdata_ff(wrd), .win_ack_ff(wa), .win_err_ff(we),
      .op_offset_ff(oofs), .op_wdata_ff(owd), .op_write_ff(ow),
      .op_read_ff(orr), .op_rdata(ord), .reading_data(rdg),
      .reading_pop(pop), .upload_bytes(ub), .window_base(wbase),
      .cfg_base(cbase));
   task chk(input logic [23:0] g, x);
      total_checks++;
      if (g !== x) begin
         num_errors++;
         $display("mismatch %0t got %h exp %h", $time, g, x);
      end
   endtask
   task rst(input logic d, input logic [7:0] a);
      {nrst, use_def, la} = {1'b0, d, a};
      repeat (5) @(posedge sys_clk);
      #1 nrst = 1;
      // switch pins pass three stages before the address is caught
      repeat (6) @(posedge sys_clk);
      #1;
   endtask
   task wacc(input logic wr, w, input logic [11:0] o, input logic [15:0] d);
      i_master.acc(1, wr, w, wb + o, d, ack, err, q);
   endtask
   task close_out;
      if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      v = $urandom(32'h7249931b);
      rst(1, 8'h00);
      chk(cbase, 24'h1FCA00);
      la = $urandom;
      rst(0, la);
      cb = 24'h1FC000 + {la, 6'h00};
      chk(cbase, cb);
      i_master.acc(0, 0, 0, cb + 24'h2, 16'h0, ack, err, q);
      chk({ack, q[15:12]}, 5'h10);
      i_master.acc(0, 0, 0, cb + 24'h40, 16'h0, ack, err, q);
      chk(ack, 0);
      v = $urandom;
      i_master.acc(0, 1, 0, cb + 24'h6, v, ack, err, q);
      i_master.acc(0, 0, 0, cb + 24'h6, 16'h0, ack, err, q);
      chk({ack, q}, {1'b1, v});
      wb = {v, 8'h00};
      chk(wbase, wb);
      for (int i = 0; i < 4; i++) begin
         e = i == 3 ? ($urandom & 12'hFF0) | 1 : i == 2 ? 12'hFFF : 12'h41;
         wacc(0, 0, e[11:0], 16'h0);
         chk({ack, q}, {1'b1, 8'h00, e[7:0] ^ 8'h5A});
      end
      wacc(1, 0, 12'h045, 16'hBEEF);
      chk({ack, owd}, 9'h1EF);
      i_master.acc(1, 0, 0, wb + 24'h1000, 16'h0, ack, err, q);
      chk(ack, 0);
      i_master.acc(1, 0, 0, wb - 24'h1, 16'h0, ack, err, q);
      chk(ack, 0);
      wacc(0, 1, 12'h041, 16'h0);
      chk({ack, err}, 2'b01);
      e = 16'hA1B2;
      for (int k = 0; k < 2; k++) begin
         wacc(0, 0, 12'h00C, 16'h0);
         chk(q, e[15:8]);
         wacc(0, 0, 12'h00C, 16'h0);
         chk(q, e[7:0]);
         e += 16'h1357;
         nb += 2;
      end
      chk(ub, nb);
      wacc(0, 1, 12'h00C, 16'h0);
      nb += 2;
      chk({ack, err, q}, {2'b10, e});
      chk(ub, nb);
      close_out;
   end
endmodule
